// ### prhc_defs.vh
// Register map, field positions and reset values for the reference/holdover control block
`ifndef PRHC_DEFS_VH
`define PRHC_DEFS_VH

// ----------------------------------------------------------------------------
// Register indices and address width
// ----------------------------------------------------------------------------
`define PRHC_IDX_REF_CTRL     8'h1C
`define PRHC_IDX_HOLD_CTRL    8'h1D
`define PRHC_IDX_STATUS       8'h1F
`define PRHC_IDX_IRQ_STATUS   8'h20
`define PRHC_IDX_IRQ_MASK     8'h21
`define PRHC_IDX_THRESH_CTRL  8'h1A
`define PRHC_ADDR_W           12

// ----------------------------------------------------------------------------
// Reference control fields
// ----------------------------------------------------------------------------
`define PRHC_REF_DIFF_BIT     0
`define PRHC_REF_PRI_PWR_BIT  1
`define PRHC_REF_SEC_PWR_BIT  2
`define PRHC_REF_AUTO_SW_BIT  4
`define PRHC_REF_CTRL_RST     8'h00

// ----------------------------------------------------------------------------
// Holdover control fields
// ----------------------------------------------------------------------------
`define PRHC_HOLD_EN0_BIT     0
`define PRHC_HOLD_EXT_BIT     1
`define PRHC_HOLD_EN2_BIT     2
`define PRHC_HOLD_CMP_EN_BIT  3
`define PRHC_HOLD_CTRL_RST    8'h00

// ----------------------------------------------------------------------------
// Threshold select field and status fields
// ----------------------------------------------------------------------------
`define PRHC_THR_SEL_BIT      6
`define PRHC_THR_CTRL_RST     8'h00
`define PRHC_ST_LOCK_BIT      0
`define PRHC_ST_PRI_HI_BIT    1
`define PRHC_ST_SEC_HI_BIT    2
`define PRHC_ST_VCO_HI_BIT    3
`define PRHC_ST_SEC_SEL_BIT   4
`define PRHC_ST_HOLD_BIT      5
`define PRHC_ST_CAL_BIT       6
`define PRHC_STATUS_W         7
`define PRHC_IRQ_RST          8'h00

`endif

// ### prhc_sync2.v
// Two-flop synchroniser for a bus of pin-level inputs
`timescale 1ns/1ns
module prhc_sync2 #(
  parameter W = 1
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // prhc_sync2

// ### prhc_top.v
// APB register bank for PLL reference input and holdover control
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
`include "prhc_defs.vh"
module prhc_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        oscillator_calibration_done,
  input  wire        holdover_state,
  input  wire        secondary_selected,
  input  wire        vco_freq_high,
  input  wire        secondary_freq_high,
  input  wire        primary_freq_high,
  input  wire        digital_lock,
  input  wire        lock_indicator_cmp,
  output reg         primary_power_on,
  output reg         secondary_power_on,
  output reg         single_ended_mode,
  output reg         auto_switchover_en,
  output reg         lock_cmp_enable,
  output reg         holdover_enable,
  output reg         holdover_external,
  output reg         holdover_prior_lock,
  output reg         freq_thresh_sel,
  output reg         irq
);

  // --------------------------------------------------------------------------
  // Pin-level status inputs pass a synchroniser
  // --------------------------------------------------------------------------
  wire [7:0] raw_st;
  wire [7:0] sync_st;

  assign raw_st = {lock_indicator_cmp, oscillator_calibration_done, holdover_state,
                   secondary_selected, vco_freq_high, secondary_freq_high,
                   primary_freq_high, digital_lock};

  prhc_sync2 #(
    .W (8)
  ) prhc_sync2_inst (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (raw_st),
    .sync_out (sync_st)
  );

  wire [6:0] live_status;
  wire       cmp_sync;

  assign live_status = sync_st[6:0];
  assign cmp_sync    = sync_st[7];

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg  [7:0]  ref_ctrl_q;
  reg  [7:0]  hold_ctrl_q;
  reg  [7:0]  thr_ctrl_q;
  reg  [6:0]  irq_status_q;
  reg  [6:0]  irq_mask_q;
  reg  [6:0]  prev_status_q;
  reg  [6:0]  irq_status_d;
  reg  [31:0] rdata_d;

  wire [9:0]  word_idx;
  wire        aligned;
  wire        setup;
  wire        wr;
  wire        hit_ref;
  wire        hit_hold;
  wire        hit_stat;
  wire        hit_thr;
  wire        hit_is;
  wire        hit_im;
  wire        hit_any;
  wire [6:0]  events;
  wire        wr_ref;
  wire        wr_hold;
  wire        wr_thr;
  wire        wr_is;
  wire        wr_im;

  assign word_idx = paddr[11:2];
  assign aligned  = (paddr[1:0] == 2'h0);
  assign hit_ref  = aligned && (word_idx == {2'h0, `PRHC_IDX_REF_CTRL});
  assign hit_hold = aligned && (word_idx == {2'h0, `PRHC_IDX_HOLD_CTRL});
  assign hit_stat = aligned && (word_idx == {2'h0, `PRHC_IDX_STATUS});
  assign hit_thr  = aligned && (word_idx == {2'h0, `PRHC_IDX_THRESH_CTRL});
  assign hit_is   = aligned && (word_idx == {2'h0, `PRHC_IDX_IRQ_STATUS});
  assign hit_im   = aligned && (word_idx == {2'h0, `PRHC_IDX_IRQ_MASK});
  assign hit_any  = hit_ref | hit_hold | hit_stat | hit_thr | hit_is | hit_im;
  // Zero-wait slave: access completes in the first penable cycle
  assign setup    = psel && !penable;
  assign wr       = psel && penable && pready && pwrite;
  // Any change of a status bit counts as an event
  assign events   = live_status ^ prev_status_q;
  assign wr_ref   = wr && hit_ref;
  assign wr_hold  = wr && hit_hold;
  assign wr_thr   = wr && hit_thr;
  assign wr_is    = wr && hit_is;
  assign wr_im    = wr && hit_im;

  // --------------------------------------------------------------------------
  // Interrupt status: set beats write-one-to-clear
  // --------------------------------------------------------------------------
  always @* begin
    irq_status_d = irq_status_q;
    if (wr_is) begin
      irq_status_d = irq_status_q & ~pwdata[6:0];
    end
    irq_status_d = irq_status_d | events;
  end

  // --------------------------------------------------------------------------
  // Read data mux, decoded in the setup cycle
  // --------------------------------------------------------------------------
  always @* begin
    rdata_d = 32'h00000000;
    if (hit_ref) begin
      rdata_d = {24'h000000, ref_ctrl_q};
    end else if (hit_hold) begin
      rdata_d = {24'h000000, hold_ctrl_q};
    end else if (hit_thr) begin
      rdata_d = {24'h000000, thr_ctrl_q};
    end else if (hit_stat) begin
      rdata_d = {25'h0000000, live_status};
    end else if (hit_is) begin
      // Bits set in this very cycle read as set
      rdata_d = {25'h0000000, irq_status_d};
    end else if (hit_im) begin
      rdata_d = {25'h0000000, irq_mask_q};
    end
  end

  // --------------------------------------------------------------------------
  // APB handshake: one access cycle, never stretched
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      // Refused words are never written
      pslverr <= setup && !hit_any;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      // Held outside setup so the value stands through the access cycle
      prdata <= rdata_d;
    end
  end

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  // Status register has no write path
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_ctrl_q <= `PRHC_REF_CTRL_RST;
    end else if (wr_ref) begin
      ref_ctrl_q <= pwdata[7:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_ctrl_q <= `PRHC_HOLD_CTRL_RST;
    end else if (wr_hold) begin
      hold_ctrl_q <= pwdata[7:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_ctrl_q <= `PRHC_THR_CTRL_RST;
    end else if (wr_thr) begin
      thr_ctrl_q <= pwdata[7:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= 7'h00;
    end else if (wr_im) begin
      irq_mask_q <= pwdata[6:0];
    end
  end

  // --------------------------------------------------------------------------
  // Event tracking
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= 7'h00;
    end else begin
      irq_status_q <= irq_status_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_status_q <= 7'h00;
    end else begin
      prev_status_q <= live_status;
    end
  end

  // --------------------------------------------------------------------------
  // Derived control outputs
  // --------------------------------------------------------------------------
  wire auto_sw;
  wire lock_seen;

  assign auto_sw   = ref_ctrl_q[`PRHC_REF_AUTO_SW_BIT];
  // Disabled comparator reads as permanently high
  assign lock_seen = hold_ctrl_q[`PRHC_HOLD_CMP_EN_BIT] ? cmp_sync : 1'b1;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_power_on <= 1'b0;
    end else begin
      // Auto switchover lets the switchover logic own receiver power
      primary_power_on <= auto_sw | ref_ctrl_q[`PRHC_REF_PRI_PWR_BIT];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secondary_power_on <= 1'b0;
    end else begin
      secondary_power_on <= auto_sw | ref_ctrl_q[`PRHC_REF_SEC_PWR_BIT];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      single_ended_mode <= 1'b0;
    end else begin
      single_ended_mode <= ~ref_ctrl_q[`PRHC_REF_DIFF_BIT];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_switchover_en <= 1'b0;
    end else begin
      // Not blocked in differential mode; software ordering is trusted
      auto_switchover_en <= auto_sw;
    end
  end

  // --------------------------------------------------------------------------
  // Holdover controls
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cmp_enable <= 1'b0;
    end else begin
      lock_cmp_enable <= hold_ctrl_q[`PRHC_HOLD_CMP_EN_BIT];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      holdover_enable <= 1'b0;
    end else begin
      holdover_enable <= hold_ctrl_q[`PRHC_HOLD_EN2_BIT] &
                         hold_ctrl_q[`PRHC_HOLD_EN0_BIT];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      holdover_external <= 1'b0;
    end else begin
      holdover_external <= hold_ctrl_q[`PRHC_HOLD_EXT_BIT];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      holdover_prior_lock <= 1'b0;
    end else begin
      // Only meaningful to the internal controller
      holdover_prior_lock <= lock_seen & ~hold_ctrl_q[`PRHC_HOLD_EXT_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // Threshold select and interrupt
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_thresh_sel <= 1'b0;
    end else begin
      freq_thresh_sel <= thr_ctrl_q[`PRHC_THR_SEL_BIT];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      // Uses the next status so a fresh event raises irq without extra lag
      irq <= |(irq_status_d & irq_mask_q);
    end
  end

endmodule // prhc_top

// ### prhc_top_asserts.sv
// Assertion checker for the reference/holdover register bank
`timescale 1ns/1ns
module prhc_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  input wire        lock_indicator_cmp,
  input wire        primary_power_on,
  input wire        secondary_power_on,
  input wire        single_ended_mode,
  input wire        lock_cmp_enable,
  input wire        holdover_enable,
  input wire        holdover_external,
  input wire        holdover_prior_lock
);
  // Last write data; held until the next write
  logic [31:0] wd_q;
  wire         wr = psel && penable && pready && pwrite;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      wd_q <= 32'h0;
    else if (wr)
      wd_q <= pwdata;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // Properties
  // ----
  a_ready_access: assert property (psel && !penable |=> pready) else $error("pready late");
  a_slverr_unmapped: assert property (psel && !penable && paddr == 12'h000 |=> pslverr)
    else $error("no pslverr");
  a_sec_power: assert property (wr && paddr == 12'h070 |-> ##2
    secondary_power_on == (wd_q[4] | wd_q[2])) else $error("secondary power wrong");
  a_pri_power: assert property (wr && paddr == 12'h070 |-> ##2
    primary_power_on == (wd_q[4] | wd_q[1])) else $error("primary power wrong");
  a_ref_mode: assert property (wr && paddr == 12'h070 |-> ##2
    single_ended_mode == !wd_q[0]) else $error("reference mode wrong");
  a_hold_enable: assert property (wr && paddr == 12'h074 |-> ##2
    holdover_enable == (wd_q[2] & wd_q[0])) else $error("holdover enable wrong");
  a_hold_fields: assert property (wr && paddr == 12'h074 |-> ##2
    lock_cmp_enable == wd_q[3] && holdover_external == wd_q[1]) else $error("hold fields wrong");
  a_prior_default: assert property ($past(presetn) && !lock_cmp_enable &&
    !holdover_external |-> holdover_prior_lock) else $error("prior lock not forced");
  a_prior_cmp: assert property ((lock_cmp_enable && !holdover_external &&
    !lock_indicator_cmp) [*4] |-> !holdover_prior_lock) else $error("comparator ignored");
  a_ext_prior: assert property (holdover_external |-> !holdover_prior_lock)
    else $error("external mode uses internal");
  c_hold_write: cover property (wr && paddr == 12'h074);
  c_error: cover property (pslverr);
  c_cmp_lock: cover property (lock_cmp_enable && holdover_prior_lock);
endmodule // prhc_chk
bind prhc_top prhc_chk prhc_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .lock_indicator_cmp, .primary_power_on, .secondary_power_on,
  .single_ended_mode, .lock_cmp_enable, .holdover_enable, .holdover_external,
  .holdover_prior_lock);

// ### prhc_top_test.sv
// Self-checking bench for the reference/holdover register bank
`timescale 1ns/1ns
module prhc_top_test;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [6:0]  st = 7'h00;
  logic        ldc = 1'b0;
  logic [31:0] r;
  logic        e;
  int          mismatches = 0;
  int          checks_done = 0;
  int          cyc = 0;
  // Auto switchover only ever entered in single-ended mode
  logic [7:0]  rv [6] = '{8'h01, 8'h02, 8'h04, 8'h06, 8'h10, 8'h16};
  wire  [31:0] prdata;
  wire         pready, pslverr, primary_power_on, secondary_power_on, single_ended_mode;
  wire         auto_switchover_en, lock_cmp_enable, holdover_enable, holdover_external;
  wire         holdover_prior_lock, freq_thresh_sel, irq;
  prhc_top prhc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .oscillator_calibration_done(st[6]), .holdover_state(st[5]),
    .secondary_selected(st[4]), .vco_freq_high(st[3]), .secondary_freq_high(st[2]),
    .primary_freq_high(st[1]), .digital_lock(st[0]), .lock_indicator_cmp(ldc),
    .primary_power_on, .secondary_power_on, .single_ended_mode, .auto_switchover_en,
    .lock_cmp_enable, .holdover_enable, .holdover_external, .holdover_prior_lock,
    .freq_thresh_sel, .irq);
  always #4 pclk = ~pclk;
  // ----
  // Tasks
  // ----
  task cmp(input string n, input [31:0] x, input [31:0] s);
    checks_done++;
    if (s !== x) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask
  task acc(input [11:0] a, input w, input [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk iff pready);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Two edges let the registered outputs land before they are looked at
  task wr(input [11:0] a, input [31:0] d);
    acc(a, 1'b1, d);
    repeat (2) @(posedge pclk);
  endtask
  task rd(input [11:0] a, input [31:0] x);
    acc(a, 1'b0, 32'h0);
    cmp("read", x, r);
  endtask
  task results;
    $display("Checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      results;
    end
  end
  // ----
  // Tests
  // ----
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h074, 32'h0);
    foreach (rv[k]) begin
      wr(12'h070, 32'(rv[k]));
      cmp("primary", rv[k][4] | rv[k][1], primary_power_on);
      cmp("secondary", rv[k][4] | rv[k][2], secondary_power_on);
      cmp("mode", !rv[k][0], single_ended_mode);
      cmp("auto", rv[k][4], auto_switchover_en);
      rd(12'h070, 32'(rv[k]));
    end
    for (int i = 0; i < 32; i++) begin
      ldc <= i[4];
      wr(12'h074, 32'(i[3:0]));
      cmp("hold", i[2] & i[0], holdover_enable);
      cmp("ext", i[1], holdover_external);
      cmp("cmpen", i[3], lock_cmp_enable);
      cmp("prior", (i[3] ? i[4] : 1'b1) & !i[1], holdover_prior_lock);
    end
    cmp("thr", 1'b0, freq_thresh_sel);
    wr(12'h068, 32'h40);
    cmp("thr", 1'b1, freq_thresh_sel);
    for (int b = 0; b < 7; b++) begin
      st <= 7'(1 << b);
      repeat (4) @(posedge pclk);
      rd(12'h07C, 32'(1 << b));
    end
    st <= 7'h55;
    wr(12'h07C, 32'h2A);
    cmp("err", 1'b0, e);
    rd(12'h07C, 32'h55);
    acc(12'h000, 1'b0, 32'h0);
    cmp("err", 1'b1, e);
    acc(12'h071, 1'b1, 32'h1);
    cmp("err", 1'b1, e);
    wr(12'h080, 32'h7F);
    rd(12'h080, 32'h0);
    wr(12'h084, 32'h01);
    cmp("irq", 1'b0, irq);
    st <= 7'h54;
    repeat (4) @(posedge pclk);
    cmp("irq", 1'b1, irq);
    st <= 7'h14;
    repeat (4) @(posedge pclk);
    rd(12'h080, 32'h41);
    wr(12'h080, 32'h01);
    cmp("irq", 1'b0, irq);
    wr(12'h084, 32'h40);
    cmp("irq", 1'b1, irq);
    results;
  end
endmodule // prhc_top_test
